/* hdl/cfgdec_pkg.sv */
// Constants for the configuration byte decoder.
package cfgdec_pkg;

    // Configuration byte slots held in nonvolatile storage.
    localparam int unsigned NUM_BYTES = 3;
    localparam logic [1:0]  IDX_WDT   = 2'h0;
    localparam logic [1:0]  IDX_PIN   = 2'h1;
    localparam logic [1:0]  IDX_DBG   = 2'h2;

    // Field positions in the watchdog byte.
    localparam int unsigned WDT_HARD_BIT   = 0;

    // Field positions in the pin and oscillator byte.
    localparam int unsigned RST_PIN_BIT    = 7;
    localparam int unsigned FAST_START_BIT = 3;
    localparam int unsigned T1_LP_BIT      = 2;
    localparam int unsigned PB_ANALOG_BIT  = 1;
    localparam int unsigned CAPTURE_COMPARE_2_ROUTE_BIT = 0;

    // Field positions in the debug and programming byte.
    localparam int unsigned DBG_OFF_BIT    = 7;
    localparam int unsigned EXTENDED_INSTR_ENABLE_BIT      = 6;
    localparam int unsigned LVP_BIT        = 2;
    localparam int unsigned STK_RST_BIT    = 0;

    // Implemented bits of each byte; the rest store and read as zero.
    localparam logic [NUM_BYTES-1:0][7:0] IMPL_MASK = {8'hc5, 8'h8f, 8'h1f};

    // As-shipped erased contents: every implemented bit is one.
    localparam logic [NUM_BYTES-1:0][7:0] ERASED    = {8'hc5, 8'h8f, 8'h1f};

    // Port B pins that default to analog inputs.
    localparam int unsigned PB_ANALOG_PINS = 5;

    // Programming entry modes.
    typedef enum logic [1:0] {
        CFGDEC_RUN,
        CFGDEC_HV_PROG,
        CFGDEC_LV_PROG
    } cfgdec_mode_t;

endpackage : cfgdec_pkg

/* hdl/cfgdec_prog_if.sv */
// Carrier between the decoder and its programming entry logic.
`timescale 1ns/1ps
`default_nettype none
interface cfgdec_prog_if;
    logic hv_mode;
    logic lv_mode;
    logic lvp_enabled;

    modport entry (output hv_mode, output lv_mode, input lvp_enabled);
    modport user  (input hv_mode, input lv_mode, output lvp_enabled);
endinterface : cfgdec_prog_if
`default_nettype wire

/* hdl/cfgdec_nv_store.sv */
// Nonvolatile configuration byte storage with the programming write lock.
`timescale 1ns/1ps
`default_nettype none
module cfgdec_nv_store (
    // Clock and power-on erase.
    input  wire logic                                      clk,
    input  wire logic                                      por,
    // Programmer write port.
    input  wire logic                                      wr_en,
    input  wire logic [1:0]                                wr_idx,
    input  wire logic [7:0]                                wr_data,
    input  wire logic                                      hv_mode,
    // Stored contents and refusal.
    output logic      [cfgdec_pkg::NUM_BYTES-1:0][7:0]     rd_bytes,
    output logic                                           wr_refused
);
    logic [7:0] mem_q [cfgdec_pkg::NUM_BYTES];
    logic [7:0] mem_d [cfgdec_pkg::NUM_BYTES];
    logic       lvp_change;
    logic       wr_take;

    // A change of the low-voltage bit outside high-voltage mode refuses the whole byte.
    always_comb begin
        lvp_change = (wr_idx == cfgdec_pkg::IDX_DBG) &&
                     (wr_data[cfgdec_pkg::LVP_BIT] != mem_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::LVP_BIT]);
        wr_refused = wr_en && ((wr_idx > cfgdec_pkg::IDX_DBG) || (lvp_change && !hv_mode));
        wr_take    = wr_en && !wr_refused;
    end

    for (genvar i = 0; i < cfgdec_pkg::NUM_BYTES; i++) begin : g_entry
        always_comb begin
            mem_d[i] = mem_q[i];
            if (por) begin
                mem_d[i] = cfgdec_pkg::ERASED[i];
            end else if (wr_take && (wr_idx == 2'(i))) begin
                mem_d[i] = wr_data & cfgdec_pkg::IMPL_MASK[i];
            end
        end
        always_ff @(posedge clk) begin
            mem_q[i] <= mem_d[i];
        end
        assign rd_bytes[i] = mem_q[i];
    end

    a_lvp_lock_hold: assert property (@(posedge clk) disable iff (por)
        (wr_en && !hv_mode && lvp_change) |=> $stable(mem_q[cfgdec_pkg::IDX_DBG]))
        else $error("Low-voltage bit changed outside high-voltage mode.");
    a_erase_lvp_set: assert property (@(posedge clk)
        por |=> mem_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::LVP_BIT])
        else $error("Erased storage does not hold the low-voltage bit at one.");
endmodule : cfgdec_nv_store
`default_nettype wire

/* hdl/cfgdec_prog_entry.sv */
// Programming mode entry: high-voltage always, low-voltage only while enabled.
`timescale 1ns/1ps
`default_nettype none
module cfgdec_prog_entry (
    // Clock and reset.
    input  wire logic  clk,
    input  wire logic  srst,
    // Entry pins.
    input  wire logic  high_programming_level,
    input  wire logic  prog_entry_pin,
    // Mode carrier.
    cfgdec_prog_if.entry prog
);
    cfgdec_pkg::cfgdec_mode_t mode_q;
    cfgdec_pkg::cfgdec_mode_t mode_d;

    always_comb begin
        if (high_programming_level) begin
            mode_d = cfgdec_pkg::CFGDEC_HV_PROG;
        end else if (prog.lvp_enabled && prog_entry_pin && (mode_q != cfgdec_pkg::CFGDEC_HV_PROG)) begin
            mode_d = cfgdec_pkg::CFGDEC_LV_PROG;
        end else begin
            mode_d = cfgdec_pkg::CFGDEC_RUN;
        end
    end

    // The high level is honoured even during reset, as a programmer raises it on the reset pin.
    always_ff @(posedge clk) begin
        if (srst && !high_programming_level) begin
            mode_q <= cfgdec_pkg::CFGDEC_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_comb begin
        prog.hv_mode = 1'b0;
        prog.lv_mode = 1'b0;
        case (mode_q)
            cfgdec_pkg::CFGDEC_HV_PROG: prog.hv_mode = 1'b1;
            cfgdec_pkg::CFGDEC_LV_PROG: prog.lv_mode = 1'b1;
            cfgdec_pkg::CFGDEC_RUN:     prog.lv_mode = 1'b0;
            default:                    prog.hv_mode = 1'b0;
        endcase
    end

    a_hv_always_enter: assert property (@(posedge clk)
        high_programming_level |=> (mode_q == cfgdec_pkg::CFGDEC_HV_PROG))
        else $error("High programming level did not enter high-voltage mode.");
    a_lv_needs_lvp: assert property (@(posedge clk) disable iff (srst)
        (!prog.lvp_enabled && mode_q != cfgdec_pkg::CFGDEC_LV_PROG) |=> (mode_q != cfgdec_pkg::CFGDEC_LV_PROG))
        else $error("Low-voltage entry taken while disabled.");
endmodule : cfgdec_prog_entry
`default_nettype wire

/* hdl/cfgdec_top.sv */
// Configuration byte decoder: latches stored bytes and drives static controls.
//
// Function
// - Watchdog hard bit forces watchdog running.
// - Reset-pin bit: master reset or plain input.
// - Fast start passes oscillator; else waits stable.
// - Timer1 oscillator low power when bit set.
// - Port B pins 4..0 analog after reset.
// - Capture/compare 2 on C1 or B3.
// - Debugger bit frees or claims B6, B7.
// - Extended instructions and indexed addressing enable.
// - Low-voltage bit makes B5 programming entry.
// - Stack fault resets only when enabled.
// - Erased low-voltage bit reads one.
// - Low-voltage bit writable only in high-voltage.
// - Cleared low-voltage bit leaves high-voltage entry only.
// - High programming level always enters programming.
`timescale 1ns/1ps
`default_nettype none
module cfgdec_top (
    // Clock, reset and power-on erase.
    input  wire logic                                   clk,
    input  wire logic                                   srst,
    input  wire logic                                   por,
    // Programmer pins.
    input  wire logic                                   high_programming_level,
    input  wire logic                                   prog_entry_pin,
    input  wire logic                                   prog_wr_en,
    input  wire logic [1:0]                             prog_wr_idx,
    input  wire logic [7:0]                             prog_wr_data,
    // Device status inputs.
    input  wire logic                                   watchdog_soft_enable,
    input  wire logic                                   master_reset_pin,
    input  wire logic                                   osc_stable_flag,
    input  wire logic                                   stack_overflow,
    input  wire logic                                   stack_underflow,
    // Watchdog and reset pin.
    output logic                                        watchdog_run_q,
    output logic                                        reset_pin_enable_q,
    output logic                                        port_e_pin_3_input_q,
    output logic                                        ext_master_reset_q,
    // Oscillators.
    output logic                                        osc_out_enable_q,
    output logic                                        timer1_low_power_osc_q,
    // Pin defaults and routing.
    output logic [cfgdec_pkg::PB_ANALOG_PINS-1:0]       port_b_analog_default_q,
    output logic                                        capcomp2_on_port_c_pin_1_q,
    output logic                                        capcomp2_on_port_b_pin_3_q,
    output logic                                        debugger_enable_q,
    output logic                                        port_b_pin_6_7_gpio_q,
    // Core and programming controls.
    output logic                                        extended_instr_enable_q,
    output logic                                        low_voltage_prog_enable_q,
    output logic                                        port_b_pin_5_gpio_q,
    output logic                                        stack_fault_reset_q,
    output logic                                        hv_prog_mode_q,
    output logic                                        lv_prog_mode_q,
    output logic                                        prog_wr_refused_q
);
    cfgdec_prog_if prog ();

    logic [cfgdec_pkg::NUM_BYTES-1:0][7:0] nv_bytes;
    logic [cfgdec_pkg::NUM_BYTES-1:0][7:0] cfg_q;
    logic [cfgdec_pkg::NUM_BYTES-1:0][7:0] cfg_d;
    logic                                  in_prog;
    logic                                  in_prog_q;
    logic                                  store_refused;
    logic                                  reload;

    logic                                  watchdog_run_d;
    logic                                  reset_pin_enable_d;
    logic                                  port_e_pin_3_input_d;
    logic                                  ext_master_reset_d;
    logic                                  osc_out_enable_d;
    logic                                  timer1_low_power_osc_d;
    logic [cfgdec_pkg::PB_ANALOG_PINS-1:0] port_b_analog_default_d;
    logic                                  capcomp2_on_port_c_pin_1_d;
    logic                                  capcomp2_on_port_b_pin_3_d;
    logic                                  debugger_enable_d;
    logic                                  port_b_pin_6_7_gpio_d;
    logic                                  extended_instr_enable_d;
    logic                                  low_voltage_prog_enable_d;
    logic                                  port_b_pin_5_gpio_d;
    logic                                  stack_fault_reset_d;
    logic                                  prog_wr_refused_d;

    assign in_prog          = prog.hv_mode || prog.lv_mode;
    assign prog.lvp_enabled = cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::LVP_BIT];

    cfgdec_prog_entry u_entry (
        .clk                    (clk),
        .srst                   (srst),
        .high_programming_level (high_programming_level),
        .prog_entry_pin         (prog_entry_pin),
        .prog                   (prog.entry)
    );

    // Writes reach storage only inside a programming mode.
    cfgdec_nv_store u_store (
        .clk        (clk),
        .por        (por),
        .wr_en      (prog_wr_en && in_prog),
        .wr_idx     (prog_wr_idx),
        .wr_data    (prog_wr_data),
        .hv_mode    (prog.hv_mode),
        .rd_bytes   (nv_bytes),
        .wr_refused (store_refused)
    );

    // Latches reload during reset and when programming ends, so the latched bytes never
    // change while the core runs; new bytes take effect only after that point.
    always_comb begin
        reload = srst || (in_prog_q && !in_prog);
        cfg_d  = reload ? nv_bytes : cfg_q;
    end

    always_ff @(posedge clk) begin
        cfg_q     <= cfg_d;
        in_prog_q <= srst ? 1'b0 : in_prog;
    end

    // Decode of the latched bytes.
    always_comb begin
        watchdog_run_d = cfg_q[cfgdec_pkg::IDX_WDT][cfgdec_pkg::WDT_HARD_BIT] || watchdog_soft_enable;
        reset_pin_enable_d   = cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::RST_PIN_BIT];
        port_e_pin_3_input_d = !cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::RST_PIN_BIT];
        ext_master_reset_d   = reset_pin_enable_d && master_reset_pin;
        osc_out_enable_d = cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::FAST_START_BIT] || osc_stable_flag;
        timer1_low_power_osc_d = cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::T1_LP_BIT];
        port_b_analog_default_d = {cfgdec_pkg::PB_ANALOG_PINS{cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::PB_ANALOG_BIT]}};
        capcomp2_on_port_c_pin_1_d = cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::CAPTURE_COMPARE_2_ROUTE_BIT];
        capcomp2_on_port_b_pin_3_d = !cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::CAPTURE_COMPARE_2_ROUTE_BIT];
        debugger_enable_d     = !cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::DBG_OFF_BIT];
        port_b_pin_6_7_gpio_d = cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::DBG_OFF_BIT];
        extended_instr_enable_d = cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::EXTENDED_INSTR_ENABLE_BIT];
        low_voltage_prog_enable_d = cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::LVP_BIT];
        port_b_pin_5_gpio_d = !cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::LVP_BIT] && !prog.lv_mode;
        stack_fault_reset_d = cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::STK_RST_BIT] &&
                              (stack_overflow || stack_underflow);
        prog_wr_refused_d = prog_wr_en && (!in_prog || store_refused);
    end

    // While reset is held every control sits at its quiet value.
    always_ff @(posedge clk) begin
        if (srst) begin
            watchdog_run_q             <= 1'b0;
            reset_pin_enable_q         <= 1'b0;
            port_e_pin_3_input_q       <= 1'b0;
            ext_master_reset_q         <= 1'b0;
            osc_out_enable_q           <= 1'b0;
            timer1_low_power_osc_q     <= 1'b0;
            port_b_analog_default_q    <= '0;
            capcomp2_on_port_c_pin_1_q <= 1'b0;
            capcomp2_on_port_b_pin_3_q <= 1'b0;
            debugger_enable_q          <= 1'b0;
            port_b_pin_6_7_gpio_q      <= 1'b0;
            extended_instr_enable_q    <= 1'b0;
            low_voltage_prog_enable_q  <= 1'b0;
            port_b_pin_5_gpio_q        <= 1'b0;
            stack_fault_reset_q        <= 1'b0;
            hv_prog_mode_q             <= 1'b0;
            lv_prog_mode_q             <= 1'b0;
            prog_wr_refused_q          <= 1'b0;
        end else begin
            watchdog_run_q             <= watchdog_run_d;
            reset_pin_enable_q         <= reset_pin_enable_d;
            port_e_pin_3_input_q       <= port_e_pin_3_input_d;
            ext_master_reset_q         <= ext_master_reset_d;
            osc_out_enable_q           <= osc_out_enable_d;
            timer1_low_power_osc_q     <= timer1_low_power_osc_d;
            port_b_analog_default_q    <= port_b_analog_default_d;
            capcomp2_on_port_c_pin_1_q <= capcomp2_on_port_c_pin_1_d;
            capcomp2_on_port_b_pin_3_q <= capcomp2_on_port_b_pin_3_d;
            debugger_enable_q          <= debugger_enable_d;
            port_b_pin_6_7_gpio_q      <= port_b_pin_6_7_gpio_d;
            extended_instr_enable_q    <= extended_instr_enable_d;
            low_voltage_prog_enable_q  <= low_voltage_prog_enable_d;
            port_b_pin_5_gpio_q        <= port_b_pin_5_gpio_d;
            stack_fault_reset_q        <= stack_fault_reset_d;
            hv_prog_mode_q             <= prog.hv_mode;
            lv_prog_mode_q             <= prog.lv_mode;
            prog_wr_refused_q          <= prog_wr_refused_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_wdt_hard_run: assert property (
        cfg_q[cfgdec_pkg::IDX_WDT][cfgdec_pkg::WDT_HARD_BIT] |=> watchdog_run_q)
        else $error("Watchdog not running with hard enable set.");
    a_wdt_soft_only: assert property (
        !cfg_q[cfgdec_pkg::IDX_WDT][cfgdec_pkg::WDT_HARD_BIT] |=> (watchdog_run_q == $past(watchdog_soft_enable)))
        else $error("Watchdog does not follow the soft enable.");
    a_pin_reset_mode: assert property (
        1'b1 |=> (reset_pin_enable_q != port_e_pin_3_input_q) &&
                 (ext_master_reset_q == (reset_pin_enable_q && $past(master_reset_pin))))
        else $error("Reset pin function and input function disagree.");
    a_osc_hold_off: assert property (
        (!cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::FAST_START_BIT] && !osc_stable_flag) |=> !osc_out_enable_q)
        else $error("Oscillator output passed before it is stable.");
    a_t1_power: assert property (
        1'b1 |=> (timer1_low_power_osc_q == $past(cfg_q[cfgdec_pkg::IDX_PIN][cfgdec_pkg::T1_LP_BIT])))
        else $error("Timer1 oscillator power level wrong.");
    a_pb_analog_reset: assert property (
        $fell(srst) |=> ##1 (port_b_analog_default_q ==
            {cfgdec_pkg::PB_ANALOG_PINS{$past(nv_bytes[cfgdec_pkg::IDX_PIN][cfgdec_pkg::PB_ANALOG_BIT], 3)}}))
        else $error("Port B analog default not taken from storage at reset.");
    a_capture_compare_2_route: assert property (
        1'b1 |=> (capcomp2_on_port_c_pin_1_q != capcomp2_on_port_b_pin_3_q))
        else $error("Capture/compare 2 routed to both or neither pin.");
    a_debug_pins: assert property (
        !cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::DBG_OFF_BIT] |=> debugger_enable_q && !port_b_pin_6_7_gpio_q)
        else $error("Debugger pins not claimed.");
    a_extended_instr_enable_mode: assert property (
        $changed(extended_instr_enable_q) |-> $past(reload, 2) || $past(srst))
        else $error("Extended instruction mode changed without reload.");
    a_pgm_pin_io: assert property (
        low_voltage_prog_enable_q |-> !port_b_pin_5_gpio_q)
        else $error("Programming entry pin used as I/O while enabled.");
    a_stack_reset: assert property (
        (stack_overflow || stack_underflow) |=> (stack_fault_reset_q == $past(
            cfg_q[cfgdec_pkg::IDX_DBG][cfgdec_pkg::STK_RST_BIT])))
        else $error("Stack fault reset does not follow its enable.");
    a_wr_refused_run: assert property (
        (prog_wr_en && !in_prog) |=> prog_wr_refused_q)
        else $error("Write outside programming mode not refused.");
    a_static_cfg: assert property (
        !reload |=> $stable(cfg_q))
        else $error("Latched configuration changed without reload.");

    c_hv_entry:   cover property ($rose(prog.hv_mode));
    c_lv_entry:   cover property ($rose(prog.lv_mode));
    c_lvp_refuse: cover property (prog_wr_en && prog.lv_mode && store_refused);
    c_reload:     cover property (in_prog_q && !in_prog);

endmodule : cfgdec_top
`default_nettype wire

/* testbench/cfgdec_prog_model.sv */
// Programmer model driving the programming pins and the byte write strobe.
`timescale 1ns/1ps
`default_nettype none
module cfgdec_prog_model (
    // Clock.
    input  wire logic       clk,
    // Programming pins.
    output logic            high_programming_level,
    output logic            prog_entry_pin,
    output logic            prog_wr_en,
    output logic [1:0]      prog_wr_idx,
    output logic [7:0]      prog_wr_data
);
    initial begin
        high_programming_level = 1'b0;
        prog_entry_pin         = 1'b0;
        prog_wr_en             = 1'b0;
        prog_wr_idx            = 2'h0;
        prog_wr_data           = 8'h00;
    end

    // Pins are held long enough for mode entry or exit and the reload to finish.
    task automatic set_pins(input logic hv, input logic lv);
        @(negedge clk);
        high_programming_level = hv;
        prog_entry_pin         = lv;
        repeat (5) @(negedge clk);
    endtask : set_pins

    // One strobe per byte; released lines show the inverse so a stale value is never taken.
    task automatic write_byte(input logic [1:0] idx, input logic [7:0] data);
        @(negedge clk);
        prog_wr_en   = 1'b1;
        prog_wr_idx  = idx;
        prog_wr_data = data;
        @(negedge clk);
        prog_wr_en   = 1'b0;
        prog_wr_idx  = ~idx;
        prog_wr_data = ~data;
    endtask : write_byte
endmodule : cfgdec_prog_model
`default_nettype wire

/* testbench/test_cfgdec_top.sv */
// Self-checking bench for the configuration byte decoder.
`timescale 1ns/1ps
`default_nettype none
module test_cfgdec_top;
    logic       clk = 1'b0, srst = 1'b1, por = 1'b1, saw = 1'b0;
    logic       watchdog_soft_enable = 1'b0, master_reset_pin = 1'b0, osc_stable_flag = 1'b0;
    logic       stack_overflow = 1'b0, stack_underflow = 1'b0;
    logic       high_programming_level, prog_entry_pin, prog_wr_en;
    logic [1:0] prog_wr_idx;
    logic [7:0] prog_wr_data;
    logic       watchdog_run_q, reset_pin_enable_q, port_e_pin_3_input_q, ext_master_reset_q;
    logic       osc_out_enable_q, timer1_low_power_osc_q, capcomp2_on_port_c_pin_1_q;
    logic       capcomp2_on_port_b_pin_3_q, debugger_enable_q, port_b_pin_6_7_gpio_q;
    logic       extended_instr_enable_q, low_voltage_prog_enable_q, port_b_pin_5_gpio_q;
    logic       stack_fault_reset_q, hv_prog_mode_q, lv_prog_mode_q, prog_wr_refused_q;
    logic [4:0] port_b_analog_default_q;
    int         n_errors = 0, samples_checked = 0, cycles = 0;

    cfgdec_top        i_cfgdec_top (.*);
    cfgdec_prog_model i_cfgdec_prog_model (.*);

    always #25 clk = ~clk;

    // Sampled on the falling edge, where the registered pulse has settled.
    always @(negedge clk) begin
        cycles++;
        if (prog_wr_refused_q === 1'b1) saw = 1'b1;
        if (cycles == 2000) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    // Second phase flips every live input; both arms are seen for each except the stack fault, raised by overflow then underflow.
    task automatic decode_check(input logic [7:0] w, input logic [7:0] p, input logic [7:0] d);
        for (int ph = 0; ph < 2; ph++) begin
            @(negedge clk);
            watchdog_soft_enable = ph[0];
            osc_stable_flag      = ph[0];
            master_reset_pin     = ~ph[0];
            stack_overflow       = ~ph[0];
            stack_underflow      = ph[0];
            repeat (2) @(negedge clk);
            chk("watchdog", watchdog_run_q, w[0] | ph[0]);
            chk("reset pin", {reset_pin_enable_q, port_e_pin_3_input_q, ext_master_reset_q},
                {p[7], ~p[7], p[7] & ~ph[0]});
            chk("osc out", osc_out_enable_q, p[3] | ph[0]);
            chk("timer1", timer1_low_power_osc_q, p[2]);
            chk("analog", port_b_analog_default_q, {5{p[1]}});
            chk("route", {capcomp2_on_port_c_pin_1_q, capcomp2_on_port_b_pin_3_q}, {p[0], ~p[0]});
            chk("debugger", {debugger_enable_q, port_b_pin_6_7_gpio_q}, {~d[7], d[7]});
            chk("extended_instr_enable", extended_instr_enable_q, d[6]);
            chk("lvp", {low_voltage_prog_enable_q, port_b_pin_5_gpio_q}, {d[2], ~d[2]});
            chk("stack", stack_fault_reset_q, d[0]);
        end
    endtask : decode_check

    task automatic wr_refused(input logic [1:0] idx, input logic [7:0] data);
        @(negedge clk);
        saw = 1'b0;
        i_cfgdec_prog_model.write_byte(idx, data);
        repeat (2) @(negedge clk);
        chk("refused", saw, 1'b1);
    endtask : wr_refused

    task automatic test_erased();
        decode_check(8'h1f, 8'h8f, 8'hc5);
        $display("test erased done");
    endtask : test_erased

    task automatic test_program_zeros();
        i_cfgdec_prog_model.set_pins(1'b1, 1'b0);
        chk("hv mode", hv_prog_mode_q, 1'b1);
        for (int i = 0; i < 3; i++) i_cfgdec_prog_model.write_byte(i[1:0], 8'h00);
        i_cfgdec_prog_model.set_pins(1'b0, 1'b0);
        decode_check(8'h00, 8'h00, 8'h00);
        $display("test program zeros done");
    endtask : test_program_zeros

    task automatic test_lock();
        i_cfgdec_prog_model.set_pins(1'b0, 1'b1);
        chk("lv locked", lv_prog_mode_q, 1'b0);
        i_cfgdec_prog_model.set_pins(1'b1, 1'b1);
        chk("hv over lv", {hv_prog_mode_q, lv_prog_mode_q}, 2'b10);
        i_cfgdec_prog_model.write_byte(2'h2, 8'hc5);
        i_cfgdec_prog_model.set_pins(1'b0, 1'b0);
        i_cfgdec_prog_model.set_pins(1'b0, 1'b1);
        chk("lv mode", {lv_prog_mode_q, port_b_pin_5_gpio_q}, 2'b10);
        wr_refused(2'h2, 8'h00);
        wr_refused(2'h3, 8'h00);
        i_cfgdec_prog_model.set_pins(1'b0, 1'b0);
        wr_refused(2'h0, 8'h1f);
        $display("test lock and refusal done");
    endtask : test_lock

    // Storage keeps what was programmed; only the latches are reloaded.
    task automatic test_second_reset();
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        decode_check(8'h00, 8'h00, 8'hc5);
        $display("test second reset done");
    endtask : test_second_reset

    initial begin
        repeat (2) @(negedge clk);
        por  = 1'b0;
        srst = 1'b0;
        test_erased();
        test_program_zeros();
        test_lock();
        test_second_reset();
        results();
    end
endmodule : test_cfgdec_top
`default_nettype wire
